/* data_set_store.sv */
`timescale 1ns/10ps
// Storage for the motion data sets with one write and one registered read port.
module data_set_store #(
  parameter int DEPTH = motion_seq_pkg::DS_DEPTH,
  parameter int WIDTH = motion_seq_pkg::DS_WIDTH,
  parameter int AW = motion_seq_pkg::DSET_ADDR_BITS
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // One entry per data set; read data follows the index one clock later.
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule : data_set_store

/* motion_core_model.sv */
`timescale 1ns/10ps
// Motion core stand-in: answers each launch with a done pulse after a prompt or slow move.
module motion_core_model (
  input wire logic mclk,
  input wire logic move_start_r,
  input wire logic slow,
  output logic move_done,
  output logic standstill
);
  int wait_cnt;
  // A launch clears standstill until the movement ends with a one-cycle done pulse.
  initial begin
    move_done = 1'b0;
    standstill = 1'b1;
    forever begin
      @(negedge mclk);
      move_done = 1'b0;
      if (move_start_r === 1'b1) begin
        standstill = 1'b0;
        wait_cnt = slow ? 12 : 1;
        repeat (wait_cnt) @(negedge mclk);
        move_done = 1'b1;
        standstill = 1'b1;
      end
    end
  end
endmodule : motion_core_model

/* motion_data_set_sequencer.sv */
`timescale 1ns/10ps
// Motion sequence operating mode: starts stored data sets and chains them.
module motion_data_set_sequencer #(
  parameter int N_IN = 4
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic fieldbus_ctrl,
  input wire logic [N_IN-1:0] din,
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [15:0] par_addr,
  input wire logic [31:0] par_wdata,
  input wire logic pwr_enabled,
  input wire logic [3:0] op_state,
  input wire logic move_done,
  input wire logic standstill,
  input wire logic halt_stop,
  input wire logic fault,
  input wire logic transition_met,
  output logic [31:0] par_rdata_r,
  output logic par_err_r,
  output logic move_start_r,
  output logic [6:0] move_index_r,
  output logic [2:0] move_type_r,
  output logic mode_active_r,
  output logic positive_travel_limit_r,
  output logic negative_travel_limit_r,
  output logic pwr_enable_req_r,
  output logic output_zero_r,
  output logic output_one_r
);
  localparam int AW = motion_seq_pkg::DSET_ADDR_BITS;
  localparam int NFN = 8;

  logic [N_IN-1:0] din_s1_r, din_s2_r;
  logic [15:0] start_set_index_r, start_nxt, command_word_r, cmd_nxt, cmd_prev_r;
  logic [15:0] mode_select_param_r, mode_nxt;
  logic [1:0] cond_r, cond_nxt;
  logic [11:0] inmap_r, inmap_nxt;
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic [NFN-1:0] fn_lvl [N_IN];
  logic [NFN-1:0] fn_any;
  logic start_prev_r, confirm_prev_r, first_done_r, first_nxt;
  logic [1:0] set_sel_r, set_sel_nxt;
  logic mode_nxt_act, exit_pend_r, exit_nxt;
  logic fb_start_ev, loc_start_ev, start_ev, start_seq, abort;
  logic [6:0] start_idx;
  motion_seq_pkg::seq_state_t st_r, st_nxt;
  logic [6:0] cur_idx_r, cur_nxt, mv_idx_nxt;
  logic seq_r, seq_nxt, seq_end_r, end_nxt, mv_start_nxt;
  logic [2:0] mv_type_nxt;
  logic [15:0] rep_cnt_r, rep_nxt, cnt_eff;
  logic [31:0] ent;
  logic ds_wr, oz_nxt, oo_nxt;
  logic [15:0] state_word;

  // Two-flop synchroniser for the digital input pins.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else begin
      din_s1_r <= din;
      din_s2_r <= din_s1_r;
    end
  end

  // Each input raises the one-hot line of the function it is assigned to.
  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_in
      assign fn_lvl[g] = din_s2_r[g] ? (8'h01 << inmap_r[3*(g%4) +: 3]) : 8'h00;
    end
  endgenerate

  // Combine all inputs into one level per function.
  always_comb begin
    fn_any = '0;
    for (int i = 0; i < N_IN; i++) begin
      fn_any = fn_any | fn_lvl[i];
    end
  end

  assign ds_wr = par_wr && (par_addr[15:AW] == motion_seq_pkg::ADDR_DSET_BASE[15:AW]);
  assign state_word = 16'(seq_end_r) << motion_seq_pkg::STAT_SEQ_END_BIT;

  // Parameter writes and reads; out-of-range start set and condition values are refused and flagged.
  always_comb begin
    start_nxt = start_set_index_r;
    cmd_nxt = command_word_r;
    mode_nxt = mode_select_param_r;
    cond_nxt = cond_r;
    inmap_nxt = inmap_r;
    rdata_nxt = par_rdata_r;
    err_nxt = 1'b0;
    if (par_wr) begin
      case (par_addr)
        motion_seq_pkg::ADDR_START_SET: begin
          if (par_wdata[15:0] <= motion_seq_pkg::START_SET_MAX) start_nxt = par_wdata[15:0];
          else err_nxt = 1'b1;
        end
        motion_seq_pkg::ADDR_CMD: cmd_nxt = par_wdata[15:0];
        motion_seq_pkg::ADDR_MODE: mode_nxt = par_wdata[15:0];
        motion_seq_pkg::ADDR_COND: begin
          if (par_wdata[15:2] == 14'h0000) cond_nxt = par_wdata[1:0];
          else err_nxt = 1'b1;
        end
        motion_seq_pkg::ADDR_INMAP: inmap_nxt = par_wdata[11:0];
        default: err_nxt = !ds_wr;
      endcase
    end
    if (par_rd) begin
      case (par_addr)
        motion_seq_pkg::ADDR_START_SET: rdata_nxt = {16'h0000, start_set_index_r};
        motion_seq_pkg::ADDR_CMD: rdata_nxt = {16'h0000, command_word_r};
        motion_seq_pkg::ADDR_STATE: rdata_nxt = {16'h0000, state_word};
        motion_seq_pkg::ADDR_MODE: rdata_nxt = {16'h0000, mode_select_param_r};
        motion_seq_pkg::ADDR_COND: rdata_nxt = {30'h00000000, cond_r};
        motion_seq_pkg::ADDR_INMAP: rdata_nxt = {20'h00000, inmap_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Fieldbus start edge; a bit held high starts nothing further.
  assign fb_start_ev = fieldbus_ctrl && command_word_r[motion_seq_pkg::CMD_START_BIT]
    && !cmd_prev_r[motion_seq_pkg::CMD_START_BIT];

  // Local start: the chosen condition applies to the first start, later ones use edges.
  always_comb begin
    logic lvl;
    lvl = fn_any[motion_seq_pkg::FN_START];
    if (first_done_r) loc_start_ev = lvl && !start_prev_r;
    else begin
      case (cond_r)
        motion_seq_pkg::COND_RISE: loc_start_ev = lvl && !start_prev_r;
        motion_seq_pkg::COND_FALL: loc_start_ev = !lvl && start_prev_r;
        motion_seq_pkg::COND_HIGH: loc_start_ev = lvl;
        default: loc_start_ev = !lvl;
      endcase
    end
    loc_start_ev = loc_start_ev && !fieldbus_ctrl;
  end

  assign start_ev = mode_active_r && (fb_start_ev || loc_start_ev);
  assign start_seq = fieldbus_ctrl ? command_word_r[motion_seq_pkg::CMD_SEQ_BIT] : 1'b1;
  assign start_idx = (fieldbus_ctrl && start_seq && command_word_r[motion_seq_pkg::CMD_SRC_BIT])
    ? start_set_index_r[6:0] : {5'h00, set_sel_r};
  assign abort = halt_stop || fault || !mode_active_r;

  // Mode entry and exit, set-number latch and first-start tracking.
  always_comb begin
    mode_nxt_act = mode_active_r;
    exit_nxt = exit_pend_r;
    set_sel_nxt = set_sel_r;
    first_nxt = first_done_r || (start_ev && !fieldbus_ctrl);
    if (!fieldbus_ctrl) begin
      exit_nxt = 1'b0;
      if (!pwr_enabled) mode_nxt_act = 1'b0;
      else if (pwr_enabled && !pwr_enable_req_r && mode_select_param_r == motion_seq_pkg::MODE_CODE_SEQ)
        mode_nxt_act = 1'b1;
    end else if (par_wr && par_addr == motion_seq_pkg::ADDR_MODE) begin
      if (par_wdata[15:0] == motion_seq_pkg::MODE_CODE_SEQ) begin
        mode_nxt_act = 1'b1;
        exit_nxt = 1'b0;
      end else exit_nxt = mode_active_r;
    end else if (exit_pend_r && standstill && (st_r == motion_seq_pkg::ST_IDLE
        || st_r == motion_seq_pkg::ST_WAIT)) begin
      mode_nxt_act = 1'b0;
      exit_nxt = 1'b0;
    end
    if (mode_nxt_act && !mode_active_r) first_nxt = 1'b0;
    if (fn_any[motion_seq_pkg::FN_CONFIRM] && !confirm_prev_r)
      set_sel_nxt = {fn_any[motion_seq_pkg::FN_SET_BIT1], fn_any[motion_seq_pkg::FN_SET_BIT0]};
  end

  assign cnt_eff = (ent[31:16] == 16'h0000) ? motion_seq_pkg::DS_COUNT_MIN : ent[31:16];

  // Sequencer: fetch a set, launch it, then chain, wait or finish.
  always_comb begin
    st_nxt = st_r;
    cur_nxt = cur_idx_r;
    seq_nxt = seq_r;
    rep_nxt = rep_cnt_r;
    end_nxt = seq_end_r;
    mv_start_nxt = 1'b0;
    mv_idx_nxt = move_index_r;
    mv_type_nxt = move_type_r;
    case (st_r)
      motion_seq_pkg::ST_IDLE: begin
        if (start_ev) begin
          st_nxt = motion_seq_pkg::ST_FETCH;
          cur_nxt = start_idx;
          seq_nxt = start_seq;
          rep_nxt = 16'h0000;
          end_nxt = 1'b0;
        end
      end
      motion_seq_pkg::ST_FETCH: st_nxt = abort ? motion_seq_pkg::ST_IDLE : motion_seq_pkg::ST_LAUNCH;
      motion_seq_pkg::ST_LAUNCH: begin
        if (abort) st_nxt = motion_seq_pkg::ST_IDLE;
        else if (ent[2:0] == motion_seq_pkg::DS_REPEAT) begin
          if (seq_r && rep_cnt_r < cnt_eff) begin
            rep_nxt = rep_cnt_r + 16'h0001;
            cur_nxt = ent[11:5];
            st_nxt = motion_seq_pkg::ST_FETCH;
          end else st_nxt = seq_r ? motion_seq_pkg::ST_DONE : motion_seq_pkg::ST_IDLE;
        end else begin
          mv_start_nxt = 1'b1;
          mv_idx_nxt = cur_idx_r;
          mv_type_nxt = ent[2:0];
          st_nxt = motion_seq_pkg::ST_MOVING;
        end
      end
      motion_seq_pkg::ST_MOVING: begin
        if (abort) st_nxt = motion_seq_pkg::ST_IDLE;
        else if (move_done) begin
          if (seq_r && ent[motion_seq_pkg::DS_HAS_NEXT_BIT]) begin
            if (ent[motion_seq_pkg::DS_HAS_TRANS_BIT]) st_nxt = motion_seq_pkg::ST_WAIT;
            else begin
              cur_nxt = ent[11:5];
              st_nxt = motion_seq_pkg::ST_FETCH;
            end
          end else if (seq_r) st_nxt = motion_seq_pkg::ST_DONE;
          else st_nxt = motion_seq_pkg::ST_IDLE;
        end
      end
      motion_seq_pkg::ST_WAIT: begin
        if (abort) st_nxt = motion_seq_pkg::ST_IDLE;
        else if (transition_met) begin
          cur_nxt = ent[11:5];
          st_nxt = motion_seq_pkg::ST_FETCH;
        end
      end
      motion_seq_pkg::ST_DONE: begin
        end_nxt = 1'b1;
        st_nxt = motion_seq_pkg::ST_IDLE;
      end
      default: st_nxt = motion_seq_pkg::ST_IDLE;
    endcase
  end

  // Signal outputs follow operating state; under local control output zero shows the wait state instead.
  always_comb begin
    oo_nxt = (op_state == motion_seq_pkg::OPST_ENABLED);
    if (fieldbus_ctrl) oz_nxt = (op_state == motion_seq_pkg::OPST_READY)
      || (op_state == motion_seq_pkg::OPST_SWITCHED_ON) || oo_nxt;
    else oz_nxt = (st_r == motion_seq_pkg::ST_WAIT);
  end

  // Register all state.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      start_set_index_r <= motion_seq_pkg::START_SET_RESET;
      command_word_r <= 16'h0000;
      cmd_prev_r <= 16'h0000;
      mode_select_param_r <= motion_seq_pkg::MODE_RESET;
      cond_r <= motion_seq_pkg::COND_RESET;
      inmap_r <= motion_seq_pkg::INMAP_RESET;
      par_rdata_r <= 32'h00000000;
      par_err_r <= 1'b0;
      start_prev_r <= 1'b0;
      confirm_prev_r <= 1'b0;
      first_done_r <= 1'b0;
      set_sel_r <= 2'h0;
      mode_active_r <= 1'b0;
      exit_pend_r <= 1'b0;
      st_r <= motion_seq_pkg::ST_IDLE;
      cur_idx_r <= 7'h00;
      seq_r <= 1'b0;
      rep_cnt_r <= 16'h0000;
      seq_end_r <= 1'b0;
      move_start_r <= 1'b0;
      move_index_r <= 7'h00;
      move_type_r <= 3'h0;
      positive_travel_limit_r <= 1'b0;
      negative_travel_limit_r <= 1'b0;
      pwr_enable_req_r <= 1'b0;
      output_zero_r <= 1'b0;
      output_one_r <= 1'b0;
    end else begin
      start_set_index_r <= start_nxt;
      command_word_r <= cmd_nxt;
      cmd_prev_r <= command_word_r;
      mode_select_param_r <= mode_nxt;
      cond_r <= cond_nxt;
      inmap_r <= inmap_nxt;
      par_rdata_r <= rdata_nxt;
      par_err_r <= err_nxt;
      start_prev_r <= fn_any[motion_seq_pkg::FN_START];
      confirm_prev_r <= fn_any[motion_seq_pkg::FN_CONFIRM];
      first_done_r <= first_nxt;
      set_sel_r <= set_sel_nxt;
      mode_active_r <= mode_nxt_act;
      exit_pend_r <= exit_nxt;
      st_r <= st_nxt;
      cur_idx_r <= cur_nxt;
      seq_r <= seq_nxt;
      rep_cnt_r <= rep_nxt;
      seq_end_r <= end_nxt;
      move_start_r <= mv_start_nxt;
      move_index_r <= mv_idx_nxt;
      move_type_r <= mv_type_nxt;
      positive_travel_limit_r <= fn_any[motion_seq_pkg::FN_POS_LIMIT];
      negative_travel_limit_r <= fn_any[motion_seq_pkg::FN_NEG_LIMIT];
      pwr_enable_req_r <= fn_any[motion_seq_pkg::FN_ENABLE];
      output_zero_r <= oz_nxt;
      output_one_r <= oo_nxt;
    end
  end

  data_set_store u_store (
    .mclk(mclk),
    .wr_en(ds_wr),
    .wr_idx(par_addr[AW-1:0]),
    .wr_data(par_wdata),
    .rd_idx(cur_idx_r),
    .rd_data(ent)
  );

  property p_fb_start;
    @(posedge mclk) disable iff (!reset_n)
    (st_r == motion_seq_pkg::ST_IDLE && mode_active_r && fb_start_ev) |=> st_r == motion_seq_pkg::ST_FETCH;
  endproperty
  a_fb_start: assert property (p_fb_start) else $error("Start edge not taken.");
  property p_held_start;
    @(posedge mclk) disable iff (!reset_n)
    (fieldbus_ctrl && st_r == motion_seq_pkg::ST_IDLE && cmd_prev_r[4] && command_word_r[4])
      |=> st_r == motion_seq_pkg::ST_IDLE;
  endproperty
  a_held_start: assert property (p_held_start) else $error("Held start bit restarted.");
  property p_src_idx;
    @(posedge mclk) disable iff (!reset_n)
    (st_r == motion_seq_pkg::ST_IDLE && start_ev && fieldbus_ctrl && command_word_r[5] && command_word_r[6])
      |=> cur_idx_r == $past(start_set_index_r[6:0]) && seq_r;
  endproperty
  a_src_idx: assert property (p_src_idx) else $error("Sequence start index wrong.");
  property p_seq_end;
    @(posedge mclk) disable iff (!reset_n)
    st_r == motion_seq_pkg::ST_DONE |=> seq_end_r && st_r == motion_seq_pkg::ST_IDLE;
  endproperty
  a_seq_end: assert property (p_seq_end) else $error("Sequence end not flagged.");
  property p_single;
    @(posedge mclk) disable iff (!reset_n)
    (st_r == motion_seq_pkg::ST_MOVING && move_done && !seq_r) |=> st_r == motion_seq_pkg::ST_IDLE ##1 !move_start_r;
  endproperty
  a_single: assert property (p_single) else $error("Single run chained on.");
  property p_wait;
    @(posedge mclk) disable iff (!reset_n)
    (st_r == motion_seq_pkg::ST_WAIT && !transition_met && !abort) |=> st_r == motion_seq_pkg::ST_WAIT;
  endproperty
  a_wait: assert property (p_wait) else $error("Successor started before condition.");
  property p_active;
    @(posedge mclk) disable iff (!reset_n)
    ##1 output_one_r == ($past(op_state) == motion_seq_pkg::OPST_ENABLED);
  endproperty
  a_active: assert property (p_active) else $error("Output one mismatch.");
  property p_start_range;
    @(posedge mclk) disable iff (!reset_n)
    (par_wr && par_addr == motion_seq_pkg::ADDR_START_SET && par_wdata[15:0] > 16'h007f)
      |=> $stable(start_set_index_r) && par_err_r;
  endproperty
  a_start_range: assert property (p_start_range) else $error("Out-of-range index kept.");
  property p_local_off;
    @(posedge mclk) disable iff (!reset_n)
    (!fieldbus_ctrl && !pwr_enabled) |=> !mode_active_r;
  endproperty
  a_local_off: assert property (p_local_off) else $error("Mode kept without power.");
endmodule : motion_data_set_sequencer

/* motion_seq_pkg.sv */
package motion_seq_pkg;
  // Parameter addresses.
  localparam logic [15:0] ADDR_START_SET = 16'h1b14;
  localparam logic [15:0] ADDR_CMD = 16'h1b00;
  localparam logic [15:0] ADDR_STATE = 16'h1b02;
  localparam logic [15:0] ADDR_MODE = 16'h1b04;
  localparam logic [15:0] ADDR_COND = 16'h1b06;
  localparam logic [15:0] ADDR_INMAP = 16'h1b08;
  localparam logic [15:0] ADDR_DSET_BASE = 16'h1c00;
  localparam int DSET_ADDR_BITS = 7;
  // Reset values and limits.
  localparam logic [15:0] START_SET_RESET = 16'h0000;
  localparam logic [15:0] START_SET_MAX = 16'h007f;
  localparam logic [15:0] MODE_CODE_SEQ = 16'h0010;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [1:0] COND_RESET = 2'h0;
  localparam logic [11:0] INMAP_RESET = 12'h8d1;
  // Command and state word bits.
  localparam int CMD_START_BIT = 4;
  localparam int CMD_SEQ_BIT = 5;
  localparam int CMD_SRC_BIT = 6;
  localparam int CMD_RSVD_BIT = 9;
  localparam int STAT_SEQ_END_BIT = 10;
  // Operating states reported by the drive state machine.
  localparam logic [3:0] OPST_READY = 4'h4;
  localparam logic [3:0] OPST_SWITCHED_ON = 4'h5;
  localparam logic [3:0] OPST_ENABLED = 4'h6;
  // Data set entry layout.
  localparam int DS_WIDTH = 32;
  localparam int DS_DEPTH = 128;
  localparam int DS_TYPE_LSB = 0;
  localparam int DS_HAS_NEXT_BIT = 3;
  localparam int DS_HAS_TRANS_BIT = 4;
  localparam int DS_NEXT_LSB = 5;
  localparam int DS_COUNT_LSB = 16;
  localparam logic [15:0] DS_COUNT_MIN = 16'h0001;
  typedef enum logic [2:0] {
    DS_ABS = 3'h0, DS_ADD = 3'h1, DS_REL = 3'h2, DS_VEL = 3'h3,
    DS_REF_MOVE = 3'h4, DS_POS_SET = 3'h5, DS_REPEAT = 3'h6, DS_PAR_WRITE = 3'h7
  } ds_type_t;
  // Signal input functions, three bits per input.
  typedef enum logic [2:0] {
    FN_NONE = 3'h0, FN_POS_LIMIT = 3'h1, FN_NEG_LIMIT = 3'h2, FN_ENABLE = 3'h3,
    FN_START = 3'h4, FN_CONFIRM = 3'h5, FN_SET_BIT0 = 3'h6, FN_SET_BIT1 = 3'h7
  } in_fn_t;
  // Sequence start conditions.
  localparam logic [1:0] COND_RISE = 2'h0;
  localparam logic [1:0] COND_FALL = 2'h1;
  localparam logic [1:0] COND_HIGH = 2'h2;
  localparam logic [1:0] COND_LOW = 2'h3;
  // Sequencer states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_FETCH = 3'h1, ST_LAUNCH = 3'h3,
    ST_MOVING = 3'h2, ST_WAIT = 3'h6, ST_DONE = 3'h4
  } seq_state_t;
endpackage : motion_seq_pkg

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam logic [15:0] A_CMD = motion_seq_pkg::ADDR_CMD;
  localparam logic [15:0] A_SET = motion_seq_pkg::ADDR_START_SET;
  logic mclk, reset_n, fieldbus_ctrl, par_wr, par_rd, pwr_enabled, transition_met, slow;
  logic move_done, standstill, par_err_r, move_start_r, mode_active_r, err;
  logic output_zero_r, output_one_r, pos_lim, neg_lim, en_req;
  logic [3:0] din, op_state;
  logic [15:0] par_addr;
  logic [31:0] par_wdata, par_rdata_r, rd;
  logic [6:0] move_index_r;
  logic [2:0] move_type_r;
  int bad_count, cmp_count, seed, e, v;
  int ds_mem[128];
  int exp_q[$];

  motion_data_set_sequencer i_motion_data_set_sequencer (.mclk(mclk), .reset_n(reset_n),
    .fieldbus_ctrl(fieldbus_ctrl), .din(din), .par_wr(par_wr), .par_rd(par_rd),
    .par_addr(par_addr), .par_wdata(par_wdata), .pwr_enabled(pwr_enabled),
    .op_state(op_state), .move_done(move_done), .standstill(standstill), .halt_stop(1'b0),
    .fault(1'b0), .transition_met(transition_met), .par_rdata_r(par_rdata_r),
    .par_err_r(par_err_r), .move_start_r(move_start_r), .move_index_r(move_index_r),
    .move_type_r(move_type_r), .mode_active_r(mode_active_r), .positive_travel_limit_r(pos_lim),
    .negative_travel_limit_r(neg_lim), .pwr_enable_req_r(en_req), .output_zero_r(output_zero_r),
    .output_one_r(output_one_r));

  motion_core_model i_motion_core_model (.mclk(mclk), .move_start_r(move_start_r),
    .slow(slow), .move_done(move_done), .standstill(standstill));

  // Free-running 10 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // One-cycle strobe; the refusal flag is sampled in the cycle after the taking edge.
  task automatic par_write(input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk);
    par_wr = 1'b1;
    par_addr = a;
    par_wdata = d;
    @(negedge mclk);
    err = par_err_r;
    par_wr = 1'b0;
  endtask : par_write

  task automatic par_read(input logic [15:0] a);
    @(negedge mclk);
    par_rd = 1'b1;
    par_addr = a;
    @(negedge mclk);
    par_rd = 1'b0;
    @(negedge mclk);
    rd = par_rdata_r;
  endtask : par_read

  task automatic set_ds(input int idx, input int typ, input int nxt_on, input int tr, input int nx);
    ds_mem[idx] = typ | (nxt_on << 3) | (tr << 4) | (nx << 5);
    par_write(motion_seq_pkg::ADDR_DSET_BASE + 16'(idx), 32'(ds_mem[idx]));
  endtask : set_ds

  // Reference model: the list of sets a start must launch, in order.
  function automatic void plan(input int first, input bit seq);
    int i;
    i = first;
    exp_q.push_back(i);
    while (seq && ds_mem[i][3] && exp_q.size() < 10) begin
      i = (ds_mem[i] >> 5) & 127;
      exp_q.push_back(i);
    end
  endfunction : plan

  task automatic wait_q(input int n);
    int k;
    k = 0;
    while (exp_q.size() > n && k < 600) begin
      @(negedge mclk);
      k++;
    end
    check("launch wait", 32'(exp_q.size()), 32'(n));
  endtask : wait_q

  // Start with bit 4 first cleared to zero, then rewrite the same word while the start bit stays high.
  task automatic run(input logic [15:0] cmd, input int first, input bit seq, input bit hold);
    plan(first, seq);
    par_write(A_CMD, 32'h0);
    par_write(A_CMD, {16'h0, cmd});
    if (hold) begin
      wait_q(exp_q.size() - 1);
      repeat (30) @(negedge mclk);
      check("held successor", 32'(exp_q.size()), 32'h1);
      transition_met = 1'b1;
    end
    wait_q(0);
    repeat (30) @(negedge mclk);
    par_write(A_CMD, {16'h0, cmd});
    repeat (20) @(negedge mclk);
  endtask : run

  // Every launch is compared with the head of the model's list.
  always @(negedge mclk) begin
    if (move_start_r === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("extra launch", 32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        check("set index", 32'(move_index_r), 32'(e));
        check("set type", 32'(move_type_r), 32'(ds_mem[e] & 7));
      end
    end
  end

  // Watchdog against a hung sequence.
  initial begin
    #1000000;
    bad_count++;
    final_report();
  end

  // Main sequence.
  initial begin
    seed = 94208;
    {reset_n, par_wr, par_rd, pwr_enabled, slow, din, op_state} = '0;
    {fieldbus_ctrl, transition_met} = 2'b11;
    par_addr = 16'h0;
    par_wdata = 32'h0;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    par_read(A_SET);
    check("start set reset", rd, 32'h0);
    par_write(A_SET, 32'h80);
    check("range refusal", 32'(err), 32'h1);
    par_read(A_SET);
    check("kept value", rd, 32'h0);
    v = {$random(seed)} % 128;
    par_write(A_SET, 32'(v));
    par_read(A_SET);
    check("start set rw", rd, 32'(v));
    par_write(motion_seq_pkg::ADDR_STATE, 32'h400);
    check("state word ro", 32'(err), 32'h1);
    par_write(motion_seq_pkg::ADDR_MODE, 32'(motion_seq_pkg::MODE_CODE_SEQ));
    @(negedge mclk);
    check("fieldbus entry", 32'(mode_active_r), 32'h1);
    for (int s = 0; s < 8; s++) begin
      op_state = 4'(s);
      repeat (2) @(negedge mclk);
      check("active output", 32'(output_one_r), 32'(s == 6));
      check("no fault output", 32'(output_zero_r), 32'(s >= 4 && s <= 6));
    end
    for (int t = 0; t < 8; t++) begin
      if (t != 6) set_ds(16 + t, t, int'(t < 7), 0, (t == 5) ? 23 : 17 + t);
    end
    set_ds(0, 1, 1, 0, 1);
    set_ds(1, 2, 0, 0, 0);
    set_ds(7, 4, 1, 1, 8);
    set_ds(8, 5, 0, 0, 0);
    slow = 1'b1;
    par_write(A_SET, 32'h10);
    run(16'h0070, 16, 1'b1, 1'b0);
    par_read(motion_seq_pkg::ADDR_STATE);
    check("sequence end", 32'(rd[10]), 32'h1);
    slow = 1'b0;
    run(16'h0010, 0, 1'b0, 1'b0);
    run(16'h0030, 0, 1'b1, 1'b0);
    par_write(A_SET, 32'h7);
    transition_met = 1'b0;
    run(16'h0070, 7, 1'b1, 1'b1);
    par_write(motion_seq_pkg::ADDR_COND, 32'h4);
    check("cond refusal", 32'(err), 32'h1);
    par_write(motion_seq_pkg::ADDR_COND, 32'(motion_seq_pkg::COND_FALL));
    fieldbus_ctrl = 1'b0;
    repeat (3) @(negedge mclk);
    check("local exit", 32'(mode_active_r), 32'h0);
    pwr_enabled = 1'b1;
    repeat (3) @(negedge mclk);
    check("local entry", 32'(mode_active_r), 32'h1);
    plan(0, 1'b1);
    din[3] = 1'b1;
    repeat (10) @(negedge mclk);
    check("fall condition", 32'(exp_q.size()), 32'h2);
    din[3] = 1'b0;
    wait_q(0);
    din[1:0] = 2'b11;
    repeat (4) @(negedge mclk);
    check("limit inputs", {29'h0, pos_lim, neg_lim, en_req}, 32'h6);
    repeat (20) @(negedge mclk);
    final_report();
  end
endmodule : testbench
